// File: pkg/csad_pkg.sv
package csad_pkg;
  localparam int NUM_CS = 12;
  localparam int ADDR_W = 24;
  localparam int REG_W = 16;
  localparam int BUS_W = 32;
  localparam int DEC_W = 8;

  // Byte offsets on the register bus
  localparam logic [DEC_W-1:0] BASE_OFS = 8'h00;
  localparam logic [DEC_W-1:0] OPT_OFS = 8'h40;
  localparam logic [DEC_W-1:0] PIN_OFS = 8'h80;
  localparam logic [DEC_W-1:0] STAT_OFS = 8'h84;

  // Base register layout
  localparam int BLK_LSB = 0;
  localparam int BLK_W = 3;
  localparam int BASE_FLD_LSB = 3;
  localparam int ADDR_FLD_LSB = 11;

  // Option register layout
  localparam int OPT_EN_BIT = 15;
  localparam int OPT_WAIT_LSB = 0;
  localparam int OPT_WAIT_W = 4;

  // Pin assignment register layout
  localparam int PIN_SIZE_ACK_BIT = 0;

  localparam logic [REG_W-1:0] BOOT_BASE_RST = 16'h0007;
  localparam logic [REG_W-1:0] BOOT_OPT_RST = 16'h800D;
  localparam logic [REG_W-1:0] CS_BASE_RST = 16'h0000;
  localparam logic [REG_W-1:0] CS_OPT_RST = 16'h0000;
  localparam logic [REG_W-1:0] PIN_RST = 16'h0001;

  localparam logic [REG_W-1:0] BASE_INV_LO = 16'h0800;
  localparam logic [REG_W-1:0] BASE_INV_HI = 16'hF7FF;
  localparam logic [ADDR_W-1:0] ADDR_INV_LO = 24'h080000;
  localparam logic [ADDR_W-1:0] ADDR_INV_HI = 24'hF7FFFF;

  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [1:0] HTRANS_SEQ = 2'h3;

  // Lowest compared address line for each block size code
  function automatic logic [4:0] blk_low_line(input logic [BLK_W-1:0] code);
    logic [4:0] r;
    r = 5'h0B;
    case (code)
      3'h0: r = 5'h0B;
      3'h1: r = 5'h0D;
      3'h2: r = 5'h0E;
      3'h3: r = 5'h10;
      3'h4: r = 5'h11;
      3'h5: r = 5'h12;
      3'h6: r = 5'h13;
      3'h7: r = 5'h14;
      default: r = 5'h0B;
    endcase
    return r;
  endfunction
endpackage

// File: hdl/csad_chan.sv
module csad_chan #(
  parameter logic [csad_pkg::REG_W-1:0] BASE_RST = csad_pkg::CS_BASE_RST,
  parameter logic [csad_pkg::REG_W-1:0] OPT_RST = csad_pkg::CS_OPT_RST
) (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic base_we_i,
  input wire logic opt_we_i,
  input wire logic [csad_pkg::REG_W-1:0] wdata_i,
  input wire logic acc_valid_i,
  input wire logic [csad_pkg::ADDR_W-1:0] acc_addr_i,
  output logic [csad_pkg::REG_W-1:0] base_o,
  output logic [csad_pkg::REG_W-1:0] opt_o,
  output logic select_n_o,
  output logic term_o
);
  import csad_pkg::*;

  logic [REG_W-1:0] base_r, base_nxt, opt_r, opt_nxt;
  logic [OPT_WAIT_W-1:0] cnt_r, cnt_nxt;
  logic done_r, done_nxt, sel_n_r, sel_n_nxt, term_r, term_nxt;
  logic [ADDR_W-1:0] mask, base_addr;
  logic base_ok, addr_ok, hit;

  always_comb begin
    // Only lines above the block size take part in the compare
    mask = ~((24'h000001 << blk_low_line(base_r[BLK_LSB +: BLK_W])) - 24'h000001);
    base_addr = {base_r[REG_W-1:BASE_FLD_LSB], 11'h000};
    base_ok = (base_r < BASE_INV_LO) || (base_r > BASE_INV_HI);
    addr_ok = (acc_addr_i < ADDR_INV_LO) || (acc_addr_i > ADDR_INV_HI);
    // Masked low base bits make a misaligned base fall to the lower block
    hit = acc_valid_i && opt_r[OPT_EN_BIT] && base_ok && addr_ok
        && (((acc_addr_i ^ base_addr) & mask) == 24'h000000);
  end

  always_comb begin
    base_nxt = base_we_i ? wdata_i : base_r;
    opt_nxt = opt_we_i ? wdata_i : opt_r;
    sel_n_nxt = ~hit;
    cnt_nxt = cnt_r;
    done_nxt = done_r;
    term_nxt = 1'b0;
    if (!acc_valid_i) begin
      cnt_nxt = '0;
      done_nxt = 1'b0;
    end else if (hit && !done_r) begin
      if (cnt_r == opt_r[OPT_WAIT_LSB +: OPT_WAIT_W]) begin
        term_nxt = 1'b1;
        done_nxt = 1'b1;
      end else begin
        cnt_nxt = cnt_r + 4'h1;
      end
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      base_r <= BASE_RST;
      opt_r <= OPT_RST;
      cnt_r <= '0;
      done_r <= 1'b0;
      sel_n_r <= 1'b1;
      term_r <= 1'b0;
    end else if (ce_i) begin
      base_r <= base_nxt;
      opt_r <= opt_nxt;
      cnt_r <= cnt_nxt;
      done_r <= done_nxt;
      sel_n_r <= sel_n_nxt;
      term_r <= term_nxt;
    end
  end

  assign base_o = base_r;
  assign opt_o = opt_r;
  assign select_n_o = sel_n_r;
  assign term_o = term_r;
endmodule

// File: hdl/csad_ahb.sv
module csad_ahb (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  output logic [31:0] hrdata_o,
  output logic hreadyout_o,
  output logic hresp_o,
  output logic [csad_pkg::DEC_W-1:0] rd_addr_o,
  input wire logic [csad_pkg::REG_W-1:0] rd_value_i,
  output logic wr_en_o,
  output logic [csad_pkg::DEC_W-1:0] wr_addr_o,
  output logic [csad_pkg::REG_W-1:0] wr_data_o
);
  import csad_pkg::*;

  logic wpend_r, wpend_nxt;
  logic [DEC_W-1:0] waddr_r, waddr_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic take, ahb_rd;

  always_comb begin
    take = hsel_i && hready_i && (htrans_i == HTRANS_NONSEQ || htrans_i == HTRANS_SEQ);
    ahb_rd = take && !hwrite_i;
    wpend_nxt = take && hwrite_i;
    waddr_nxt = take ? haddr_i[DEC_W-1:0] : waddr_r;
    rdata_nxt = rdata_r;
    if (ahb_rd) begin
      // A write still in its data phase to the same word is forwarded
      if (wpend_r && waddr_r == haddr_i[DEC_W-1:0]) begin
        rdata_nxt = {16'h0000, hwdata_i[REG_W-1:0]};
      end else begin
        rdata_nxt = {16'h0000, rd_value_i};
      end
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      wpend_r <= 1'b0;
      waddr_r <= '0;
      rdata_r <= '0;
    end else if (ce_i) begin
      wpend_r <= wpend_nxt;
      waddr_r <= waddr_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  // A frozen block stretches the data phase rather than losing a write
  assign hreadyout_o = ce_i;
  assign hresp_o = 1'b0;
  assign hrdata_o = rdata_r;
  assign rd_addr_o = haddr_i[DEC_W-1:0];
  assign wr_en_o = wpend_r && ce_i;
  assign wr_addr_o = waddr_r;
  assign wr_data_o = hwdata_i[REG_W-1:0];
endmodule

// File: hdl/csad_top.sv
module csad_top (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  output logic [31:0] hrdata_o,
  output logic hreadyout_o,
  output logic hresp_o,
  input wire logic acc_valid_i,
  input wire logic [csad_pkg::ADDR_W-1:0] acc_addr_i,
  output logic [csad_pkg::NUM_CS-1:0] select_n_o,
  output logic cycle_term_o,
  input wire logic reset_config_line_eight_i,
  output logic size_ack_bus_mode_o
);
  import csad_pkg::*;

  logic [DEC_W-1:0] rd_addr, wr_addr;
  logic [REG_W-1:0] rd_value, wr_data, pin_r, pin_nxt;
  logic wr_en, strap_r, strap_nxt, ended_r, ended_nxt, cterm;
  logic [REG_W-1:0] base_v [NUM_CS];
  logic [REG_W-1:0] opt_v [NUM_CS];
  logic [NUM_CS-1:0] term_v, base_we, opt_we;

  csad_ahb u_ahb (
    .sys_clk_i(sys_clk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .hsel_i(hsel_i),
    .haddr_i(haddr_i),
    .htrans_i(htrans_i),
    .hwrite_i(hwrite_i),
    .hsize_i(hsize_i),
    .hwdata_i(hwdata_i),
    .hready_i(hready_i),
    .hrdata_o(hrdata_o),
    .hreadyout_o(hreadyout_o),
    .hresp_o(hresp_o),
    .rd_addr_o(rd_addr),
    .rd_value_i(rd_value),
    .wr_en_o(wr_en),
    .wr_addr_o(wr_addr),
    .wr_data_o(wr_data)
  );

  // Index 0 is the boot select, 1..11 the numbered selects; all match concurrently
  for (genvar i = 0; i < NUM_CS; i++) begin : g_cs
    assign base_we[i] = wr_en && (wr_addr == BASE_OFS + DEC_W'(4 * i));
    assign opt_we[i] = wr_en && (wr_addr == OPT_OFS + DEC_W'(4 * i));
    csad_chan #(
      .BASE_RST(i == 0 ? BOOT_BASE_RST : CS_BASE_RST),
      .OPT_RST(i == 0 ? BOOT_OPT_RST : CS_OPT_RST)
    ) u_chan (
      .sys_clk_i(sys_clk_i),
      .rst_i(rst_i),
      .ce_i(ce_i),
      .base_we_i(base_we[i]),
      .opt_we_i(opt_we[i]),
      .wdata_i(wr_data),
      .acc_valid_i(acc_valid_i),
      .acc_addr_i(acc_addr_i),
      .base_o(base_v[i]),
      .opt_o(opt_v[i]),
      .select_n_o(select_n_o[i]),
      .term_o(term_v[i])
    );
  end

  always_comb begin
    rd_value = '0;
    for (int i = 0; i < NUM_CS; i++) begin
      if (rd_addr == BASE_OFS + DEC_W'(4 * i)) begin
        rd_value = base_v[i];
      end
      if (rd_addr == OPT_OFS + DEC_W'(4 * i)) begin
        rd_value = opt_v[i];
      end
    end
    if (rd_addr == PIN_OFS) begin
      rd_value = pin_r;
    end
    if (rd_addr == STAT_OFS) begin
      rd_value = REG_W'(~select_n_o);
    end
  end

  // Strap is caught on the first enabled edge after reset release
  always_comb begin
    strap_nxt = 1'b0;
    pin_nxt = pin_r;
    if (strap_r) begin
      pin_nxt[PIN_SIZE_ACK_BIT] = reset_config_line_eight_i;
    end
    if (wr_en && wr_addr == PIN_OFS) begin
      pin_nxt = wr_data;
    end
  end

  // First termination ends the cycle; later ones in the same cycle are dropped.
  // Passed on without a register so no extra wait state is added.
  always_comb begin
    cterm = |term_v && !ended_r;
    ended_nxt = ended_r;
    if (!acc_valid_i) begin
      ended_nxt = 1'b0;
    end else if (cterm) begin
      ended_nxt = 1'b1;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      strap_r <= 1'b1;
      pin_r <= PIN_RST;
      ended_r <= 1'b0;
    end else if (ce_i) begin
      strap_r <= strap_nxt;
      pin_r <= pin_nxt;
      ended_r <= ended_nxt;
    end
  end

  assign cycle_term_o = cterm;
  assign size_ack_bus_mode_o = pin_r[PIN_SIZE_ACK_BIT];
endmodule

// File: tb/csad_properties.sv
module csad_chk (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic [31:0] hrdata_o,
  input wire logic acc_valid_i,
  input wire logic [csad_pkg::ADDR_W-1:0] acc_addr_i,
  input wire logic [csad_pkg::NUM_CS-1:0] select_n_o,
  input wire logic cycle_term_o,
  input wire logic reset_config_line_eight_i,
  input wire logic size_ack_bus_mode_o
);
  timeunit 1ns;
  timeprecision 100ps;
  import csad_pkg::*;
  logic term_seen_r;
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);
  // Remembers a termination until the access ends, so a second one is caught
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      term_seen_r <= 1'b0;
    end else if (ce_i) begin
      term_seen_r <= acc_valid_i && (term_seen_r || cycle_term_o);
    end
  end
  sel_cause_a: assert property (!(&select_n_o) |-> $past(acc_valid_i))
    else $error("select low without a bus access");
  idle_high_a: assert property ($past(ce_i) && !$past(acc_valid_i) |-> &select_n_o)
    else $error("select low after the access ended");
  term_pulse_a: assert property (cycle_term_o && ce_i |=> !cycle_term_o)
    else $error("termination longer than one cycle");
  term_cause_a: assert property (cycle_term_o |-> $past(acc_valid_i))
    else $error("termination outside an access");
  term_sel_a: assert property (cycle_term_o |-> !(&select_n_o))
    else $error("termination with no select asserted");
  bad_addr_a: assert property ($past(ce_i) && $past(acc_valid_i)
    && $past(acc_addr_i) >= ADDR_INV_LO && $past(acc_addr_i) <= ADDR_INV_HI |-> &select_n_o)
    else $error("select asserted for an unsupported address");
  upper_zero_a: assert property (hrdata_o[31:16] == 16'h0000)
    else $error("read data upper half not zero");
  strap_load_a: assert property ($fell(rst_i) && ce_i
    |=> size_ack_bus_mode_o == $past(reset_config_line_eight_i))
    else $error("pin mode not taken from strap");
  one_term_a: assert property (cycle_term_o |-> !term_seen_r)
    else $error("second termination in one access");
  cover property (!(&select_n_o));
  cover property (cycle_term_o);
  cover property ($fell(rst_i));
  cover property (!select_n_o[0] && !select_n_o[1] && !select_n_o[11]);
endmodule

bind csad_top csad_chk u_csad_chk (.sys_clk_i, .rst_i, .ce_i, .hrdata_o, .acc_valid_i,
  .acc_addr_i, .select_n_o, .cycle_term_o, .reset_config_line_eight_i, .size_ack_bus_mode_o);

// File: tb/csad_mem_model.sv
module csad_mem_model (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic [csad_pkg::NUM_CS-1:0] select_n_i,
  output logic reset_config_line_eight_o,
  output logic [csad_pkg::NUM_CS-1:0] seen_o
);
  timeunit 1ns;
  timeprecision 100ps;
  import csad_pkg::*;
  // Strap held low so the size-ack pins come up as general I/O
  assign reset_config_line_eight_o = 1'b0;
  // Sticky record of which devices were ever selected
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      seen_o <= '0;
    end else begin
      seen_o <= seen_o | ~select_n_i;
    end
  end
endmodule

// File: tb/testbench.sv
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  import csad_pkg::*;
  logic sys_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic ce_i = 1'b1;
  logic hsel_i = 1'b0;
  logic hwrite_i = 1'b0;
  logic acc_valid_i = 1'b0;
  logic [31:0] haddr_i = 32'h0;
  logic [31:0] hwdata_i = 32'h0;
  logic [31:0] hrdata_o;
  logic [31:0] rd;
  logic [1:0] htrans_i = 2'h0;
  logic [2:0] hsize_i = 3'h2;
  logic hreadyout_o, hresp_o, cycle_term_o, strap, size_ack_bus_mode_o;
  logic [ADDR_W-1:0] acc_addr_i = 24'h0;
  logic [NUM_CS-1:0] select_n_o, seen;
  int n_mismatch = 0;
  int samples_checked = 0;
  int lo[8] = '{11, 13, 14, 16, 17, 18, 19, 20};

  csad_top u_csad_top (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .ce_i(ce_i), .hsel_i(hsel_i),
    .haddr_i(haddr_i), .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hsize_i(hsize_i),
    .hwdata_i(hwdata_i), .hready_i(hreadyout_o), .hrdata_o(hrdata_o),
    .hreadyout_o(hreadyout_o), .hresp_o(hresp_o), .acc_valid_i(acc_valid_i),
    .acc_addr_i(acc_addr_i), .select_n_o(select_n_o), .cycle_term_o(cycle_term_o),
    .reset_config_line_eight_i(strap), .size_ack_bus_mode_o(size_ack_bus_mode_o));
  csad_mem_model u_csad_mem_model (.sys_clk_i(sys_clk_i), .rst_i(rst_i),
    .select_n_i(select_n_o), .reset_config_line_eight_o(strap), .seen_o(seen));

  initial begin
    forever #4 sys_clk_i = ~sys_clk_i;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic stop_test;
    $display("checked %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // Entered just after a rising edge; leaves at the edge that ends the data phase
  task automatic xfer(input logic wr, input logic [31:0] a, input logic [31:0] wd);
    hsel_i <= 1'b1;
    htrans_i <= HTRANS_NONSEQ;
    haddr_i <= a;
    hwrite_i <= wr;
    @(posedge sys_clk_i);
    while (hreadyout_o !== 1'b1) @(posedge sys_clk_i);
    hsel_i <= 1'b0;
    htrans_i <= 2'h0;
    hwdata_i <= wd;
    @(posedge sys_clk_i);
    while (hreadyout_o !== 1'b1) @(posedge sys_clk_i);
    rd = hrdata_o;
  endtask

  task automatic rdchk(input logic [31:0] a, input logic [31:0] exp);
    xfer(1'b0, a, 32'h0);
    chk(rd, exp);
    chk({31'h0, hresp_o}, 32'h0);
  endtask

  // Cycle count is W+1 for the fastest matching select, 0 when nothing terminates.
  // The access is held 21 cycles so slower selects reach their count too.
  task automatic access(input logic [23:0] a, input logic [11:0] exp_sel, input int exp_n);
    int n;
    int nt;
    logic [11:0] s;
    n = 0;
    nt = 0;
    s = 12'hFFF;
    acc_addr_i <= a;
    acc_valid_i <= 1'b1;
    for (int i = 1; i <= 20; i++) begin
      @(posedge sys_clk_i);
      #1;
      if (i == 1) s = select_n_o;
      if (cycle_term_o === 1'b1) begin
        nt++;
        if (n == 0) n = i;
      end
    end
    @(posedge sys_clk_i);
    acc_valid_i <= 1'b0;
    repeat (2) @(posedge sys_clk_i);
    chk({20'h0, s}, {20'h0, exp_sel});
    chk(n, exp_n);
    chk(nt, (exp_n > 0) ? 1 : 0);
  endtask

  initial begin
    repeat (6) @(posedge sys_clk_i);
    rst_i <= 1'b0;
    @(posedge sys_clk_i);
    rdchk(32'h00, 32'h0007);
    rdchk(32'h40, 32'h800D);
    rdchk(32'h14, 32'h0000);
    rdchk(32'hFC, 32'h0000);
    rdchk(32'h80, 32'h0000);
    chk({31'h0, size_ack_bus_mode_o}, 32'h0);
    xfer(1'b1, 32'h80, 32'h1);
    rdchk(32'h80, 32'h0001);
    chk({31'h0, size_ack_bus_mode_o}, 32'h1);
    access(24'h000100, 12'hFFE, 14);
    xfer(1'b1, 32'h04, 32'h0504);
    xfer(1'b1, 32'h44, 32'h8003);
    xfer(1'b1, 32'h2C, 32'h0400);
    xfer(1'b1, 32'h6C, 32'h800C);
    rdchk(32'h04, 32'h0504);
    access(24'h040000, 12'h7FC, 4);
    access(24'h060000, 12'hFFE, 14);
    xfer(1'b1, 32'h04, 32'h0404);
    xfer(1'b1, 32'h2C, 32'h0300);
    access(24'h040000, 12'hFFC, 4);
    access(24'h0307FF, 12'h7FE, 13);
    access(24'h030800, 12'hFFE, 14);
    xfer(1'b1, 32'h44, 32'h0003);
    xfer(1'b1, 32'h48, 32'h8000);
    // Blocks above 512K reach into the unsupported range, so their top stays unreachable
    for (int c = 0; c < 8; c++) begin
      xfer(1'b1, 32'h08, 32'(c));
      access(((24'h1 << lo[c]) - 24'h1) & 24'h07FFFF, 12'hFFA, 1);
      access(24'h1 << lo[c], lo[c] >= 19 ? 12'hFFF : 12'hFFE, lo[c] >= 19 ? 0 : 14);
    end
    xfer(1'b1, 32'h0C, 32'h0800);
    xfer(1'b1, 32'h4C, 32'h8000);
    access(24'h080000, 12'hFFF, 0);
    // Invalid base with a 1M size would cover address 0 if the base check were missing
    xfer(1'b1, 32'h0C, 32'h0807);
    access(24'h000100, 12'hFFA, 1);
    xfer(1'b1, 32'h08, 32'hF800);
    access(24'hF80000, 12'hFFB, 1);
    chk({20'h0, seen}, 32'h0807);
    stop_test;
  end

  initial begin
    #100000;
    n_mismatch++;
    stop_test;
  end
endmodule
